// ### sbc_cfg.svh
// Constants for the mode-and-supply control block and its SPI master end.
// Included by both design ends and by the bench; definitions only.
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH
`define FRAME_BITS        16
`define ADDR_BITS         7
`define WRITE_BIT         7
`define DATA_LSB          8
`define ADDR_MODE_SUPPLY  7'h01
`define ADDR_FAULT_STATUS 7'h02
`define ADDR_FAMILY_ID    7'h03
`define MODE_SUPPLY_RESET 8'h00
`define MODE_SUPPLY_KEEP  8'h07
`define MODE_SUPPLY_RSVD  8'h20
`define MODE_MSB          7
`define MODE_LSB          6
`define SEC_REG_MSB       4
`define SEC_REG_LSB       3
`define OV_RST_BIT        2
`define THRESH_MSB        1
`define THRESH_LSB        0
`define FAMILY_ID_VALUE   8'h5a
`define SCK_HALF_DIV      5'h04
// Host register offsets.
`define HOST_CMD          4'h0
`define HOST_DATA         4'h1
`define HOST_STATUS       4'h2
`define HOST_INT_STATUS   4'h3
`define HOST_INT_CLEAR    4'h4
`define HOST_INT_ENABLE   4'h5
`endif

// ### sbc_pkg.sv
// Types shared by both ends of the SPI link.
// Assumes sbc_cfg.svh is on the include path.
package sbc_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SLEEP,
        MODE_STOP,
        MODE_SOFT_RESET
    } op_mode_e;
    typedef enum logic [1:0] {
        TH_LEVEL_ONE,
        TH_LEVEL_TWO,
        TH_LEVEL_THREE,
        TH_DISABLED
    } threshold_e;
endpackage

// ### sbc_spi_if.sv
// Four-wire SPI link joining the master end and the device end.
// Assumes both ends run on their own clocks; the bench joins them.
`timescale 1ns/1ps
interface sbc_spi_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    modport master (output sck, output cs_n, output mosi, input miso);
    modport device (input sck, input cs_n, input mosi, output miso);
endinterface

// ### sbc_device.sv
// Device end: SPI slave with the mode-and-supply control register.
// Assumes SPI mode 0, MSB first, frames of 16 clocks with chip select low;
// the link pins are asynchronous and are synchronised here.
//
// Operation
// - frame is 16 bits, address then data.
// - bit 7 zero reads without change.
// - bit 7 one writes the data byte.
// - data D0..D7 sits in frame bits 8..15.
// - reset loads all power-on values.
// - restart loads restart value, keeps don't-cares.
// - read-only and reserved bits ignore writes.
// - control bits change only by SPI writes; soft reset also clears them, restart clears the upper five.
// - restart clears upper five, keeps lower three.
// - mode field requests normal, sleep, stop.
// - mode 11 soft resets, no reset pin.
// - bit 5 always reads zero.
// - secondary regulator enable depends on mode.
// - bit 2 enables overvoltage restart reset.
// - bits 1:0 pick undervoltage threshold.
// - sleep without wake source forces restart.
`timescale 1ns/1ps
`include "sbc_cfg.svh"
module sbc_device
    import sbc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    sbc_spi_if.device       spi,
    input  wire logic       wake_source_enabled,
    input  wire logic       primary_overvoltage,
    input  wire logic [7:0] fault_events,
    output logic [1:0]      op_mode,
    output logic            secondary_regulator_enable,
    output logic            primary_overvoltage_reset_enable,
    output logic [1:0]      primary_reset_threshold,
    output logic            reset_output_pin,
    output logic            restart_active
);
    logic [2:0]  sck_s_r;
    logic [1:0]  cs_s_r;
    logic [1:0]  mosi_s_r;
    logic [15:0] shift_r;
    logic [4:0]  bit_cnt_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  fault_r;
    logic [7:0]  reply_sel;
    logic [7:0]  reply_r;
    logic        miso_r;
    logic        soft_reset_r;
    logic        restart_r;
    logic        sck_rise;
    logic        sck_fall;
    logic        frame_end;
    logic        cs_low;
    logic        is_write;
    logic [6:0]  frame_addr;
    logic [7:0]  frame_data;
    logic        restart_req;
    logic [9:0]  aux_s1_r;
    logic [9:0]  aux_s2_r;
    logic        wake_s;
    logic        ov_s;
    logic [7:0]  events_s;

    // Two flops per pin, three on the clock; edges are found from the second and third stages.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sck_s_r  <= 3'h0;
            cs_s_r   <= 2'h3;
            mosi_s_r <= 2'h0;
        end else begin
            sck_s_r  <= {sck_s_r[1:0], spi.sck};
            cs_s_r   <= {cs_s_r[0], spi.cs_n};
            mosi_s_r <= {mosi_s_r[0], spi.mosi};
        end
    end

    // Board level pins are foreign to clk as well, so each passes two
    // flops. Each fault bit is an independent flag, so bits that settle a
    // cycle apart still latch correctly.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            aux_s1_r <= 10'h000;
            aux_s2_r <= 10'h000;
        end else begin
            aux_s1_r <= {wake_source_enabled, primary_overvoltage,
                         fault_events};
            aux_s2_r <= aux_s1_r;
        end
    end
    assign wake_s   = aux_s2_r[9];
    assign ov_s     = aux_s2_r[8];
    assign events_s = aux_s2_r[7:0];

    assign cs_low    = !cs_s_r[1];
    assign sck_rise  = cs_low && sck_s_r[1] && !sck_s_r[2];
    assign sck_fall  = cs_low && !sck_s_r[1] && sck_s_r[2];
    // A frame is acted on only at the sixteenth clock rise, as its last bit arrives.
    assign frame_end = sck_rise && (bit_cnt_r == 5'(`FRAME_BITS - 1));
    // First byte on the wire is frame bits 0..7, so the address byte lands
    // high in the shift register and the data byte low.
    // At the last rise only fifteen bits are held, so the first wire bit
    // sits at bit 14 and the last data bit is still on the line.
    assign frame_addr = shift_r[13:7];
    assign is_write   = shift_r[14];
    assign frame_data = {shift_r[6:0], mosi_s_r[1]};

    // Receive shifting and the bit counter; chip select high aborts a frame.
    always_ff @(posedge clk) begin
        if (!resetn || !cs_low) begin
            shift_r   <= 16'h0000;
            bit_cnt_r <= 5'h00;
        end else if (sck_rise) begin
            shift_r   <= {shift_r[14:0], mosi_s_r[1]};
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // Read data for the addressed register; the reserved bit forced to zero.
    // The address is only valid in the low bits right after eight rises.
    always_comb begin
        reply_sel = 8'h00;
        if (shift_r[6:0] == `ADDR_MODE_SUPPLY) begin
            reply_sel = ctrl_r & ~`MODE_SUPPLY_RSVD;
        end else if (shift_r[6:0] == `ADDR_FAULT_STATUS) begin
            reply_sel = fault_r;
        end else if (shift_r[6:0] == `ADDR_FAMILY_ID) begin
            reply_sel = `FAMILY_ID_VALUE; // Arbitrary identity value.
        end
    end

    // The reply byte is captured at the first fall after the address byte,
    // before data bits push the address out of the shift register, and then
    // leaves MSB first on falling edges. The line stays low before that.
    always_ff @(posedge clk) begin
        if (!resetn || !cs_low) begin
            miso_r  <= 1'b0;
            reply_r <= 8'h00;
        end else if (sck_fall && bit_cnt_r == 5'h08) begin
            miso_r  <= reply_sel[7];
            reply_r <= {reply_sel[6:0], 1'b0};
        end else if (sck_fall && bit_cnt_r > 5'h08) begin
            miso_r  <= reply_r[7];
            reply_r <= {reply_r[6:0], 1'b0};
        end
    end
    assign spi.miso = miso_r;

    // Restart comes from an enabled overvoltage or a sleep with no wake.
    // The overvoltage cause persists while the pin stays high, since the
    // enable bit survives the restart mask.
    assign restart_req = (ov_s && ctrl_r[`OV_RST_BIT])
        || (ctrl_r[`MODE_MSB:`MODE_LSB] == 2'(MODE_SLEEP)
            && !wake_s);

    // Control register: soft reset and power-on load, restart masks, writes.
    always_ff @(posedge clk) begin
        if (!resetn || soft_reset_r) begin
            ctrl_r <= `MODE_SUPPLY_RESET;
        end else if (restart_req) begin
            ctrl_r <= ctrl_r & `MODE_SUPPLY_KEEP;
        end else if (frame_end && is_write
                     && frame_addr == `ADDR_MODE_SUPPLY) begin
            ctrl_r <= frame_data & ~`MODE_SUPPLY_RSVD;
        end
    end

    // A write of mode 11 soft-resets next cycle, without the reset pin.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            soft_reset_r <= 1'b0;
        end else begin
            soft_reset_r <= !soft_reset_r && ctrl_r[`MODE_MSB:`MODE_LSB]
                            == 2'(MODE_SOFT_RESET);
        end
    end

    // Restart drives the reset pin one cycle behind its cause, for as long as the cause lasts.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= restart_req;
        end
    end

    // Fault flags latch; a read of the register clears them, but an event
    // in that same cycle wins; events after the reply byte is captured are lost.
    always_ff @(posedge clk) begin
        if (!resetn || soft_reset_r) begin
            fault_r <= 8'h00;
        end else if (frame_end && !is_write
                     && frame_addr == `ADDR_FAULT_STATUS) begin
            fault_r <= events_s;
        end else begin
            fault_r <= fault_r | events_s;
        end
    end

    // Secondary regulator on per mode selection; other fields pass out.
    always_comb begin
        op_mode = ctrl_r[`MODE_MSB:`MODE_LSB];
        primary_overvoltage_reset_enable = ctrl_r[`OV_RST_BIT];
        primary_reset_threshold = ctrl_r[`THRESH_MSB:`THRESH_LSB];
        case (ctrl_r[`SEC_REG_MSB:`SEC_REG_LSB])
            2'h1:    secondary_regulator_enable = op_mode == 2'(MODE_NORMAL);
            2'h2:    secondary_regulator_enable = op_mode == 2'(MODE_NORMAL)
                                                || op_mode == 2'(MODE_STOP);
            2'h3:    secondary_regulator_enable = op_mode != 2'(MODE_SOFT_RESET);
            default: secondary_regulator_enable = 1'b0;
        endcase
    end

    assign reset_output_pin = restart_r;
    assign restart_active   = restart_r;
endmodule

// ### sbc_master.sv
// SPI master end driving one 16-bit frame per command.
// Assumes software reaches it through a plain register port.
`timescale 1ns/1ps
`include "sbc_cfg.svh"
module sbc_master
    import sbc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    sbc_spi_if.master       spi,
    input  wire logic [3:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [15:0]     reg_rdata,
    output logic            irq
);
    typedef enum logic [1:0] {IDLE, SHIFT, DONE} state_e;
    state_e      state_r;
    logic [15:0] tx_r;
    logic [7:0]  rx_r;
    logic [4:0]  bit_cnt_r;
    logic [4:0]  div_r;
    logic        sck_r;
    logic [1:0]  miso_s_r;
    logic        done_stat_r;
    logic        done_en_r;
    logic        tick;
    logic        start;

    assign tick  = (div_r == `SCK_HALF_DIV);
    // A write to the command register while idle starts a frame. All sixteen bits
    // belong to the frame, so no start flag may share the word.
    assign start = reg_write && reg_addr == `HOST_CMD && state_r == IDLE;

    // MISO is foreign to this clock; two flops before use.
    always_ff @(posedge clk) begin
        if (!resetn) miso_s_r <= 2'h0;
        else miso_s_r <= {miso_s_r[0], spi.miso};
    end

    // Command bits 7:0 are address and write flag, bits 15:8 the data.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= IDLE;
            tx_r <= 16'h0000;
            bit_cnt_r <= 5'h00;
            div_r <= 5'h00;
            sck_r <= 1'b0;
            rx_r <= 8'h00;
        end else begin
            case (state_r)
                IDLE: begin
                    if (start) begin
                        tx_r <= {reg_wdata[7:0], reg_wdata[15:8]};
                        bit_cnt_r <= 5'h00;
                        div_r <= 5'h00;
                        state_r <= SHIFT;
                    end
                end
                SHIFT: begin
                    div_r <= tick ? 5'h00 : div_r + 5'h01;
                    if (tick) begin
                        sck_r <= !sck_r;
                        if (sck_r) begin
                            tx_r <= {tx_r[14:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                            // A reply bit launched at one fall needs about
                            // five cycles through both ends' flops, so it
                            // is taken just before the next fall.
                            if (bit_cnt_r >= 5'h08)
                                rx_r <= {rx_r[6:0], miso_s_r[1]};
                            if (bit_cnt_r == 5'(`FRAME_BITS - 1))
                                state_r <= DONE;
                        end
                    end
                end
                default: begin
                    state_r <= IDLE;
                end
            endcase
        end
    end

    // Sticky done bit; a completion beats a simultaneous clear.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            done_stat_r <= 1'b0;
            done_en_r <= 1'b0;
        end else begin
            if (reg_write && reg_addr == `HOST_INT_ENABLE)
                done_en_r <= reg_wdata[0];
            done_stat_r <= (state_r == DONE) || (done_stat_r &&
                !(reg_write && reg_addr == `HOST_INT_CLEAR && reg_wdata[0]));
        end
    end

    // Read data stand the cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (!resetn) reg_rdata <= 16'h0000;
        else if (!reg_read) reg_rdata <= 16'h0000;
        else if (reg_addr == `HOST_DATA) reg_rdata <= {8'h00, rx_r};
        else if (reg_addr == `HOST_STATUS)
            reg_rdata <= {15'h0000, state_r != IDLE};
        else if (reg_addr == `HOST_INT_STATUS)
            reg_rdata <= {15'h0000, done_stat_r};
        else if (reg_addr == `HOST_INT_ENABLE)
            reg_rdata <= {15'h0000, done_en_r};
        else reg_rdata <= 16'h0000;
    end

    assign irq      = done_stat_r && done_en_r;
    assign spi.sck  = sck_r;
    assign spi.cs_n = (state_r == IDLE);
    assign spi.mosi = tx_r[15];
endmodule

// ### sbc_link_props.sv
// Checker for the SPI link and the device end's control outputs.
// Assumes tb_top instantiates it beside the link, all inputs by name.
`timescale 1ns/1ps
module sbc_link_props (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic       mosi,
    input wire logic       wake_source_enabled,
    input wire logic       primary_overvoltage,
    input wire logic       primary_overvoltage_reset_enable,
    input wire logic [1:0] op_mode,
    input wire logic       reset_output_pin,
    input wire logic       restart_active
);
    logic [4:0] rises_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Clock rises per frame; cleared while select is high.
    always_ff @(posedge clk) begin
        if (!resetn || cs_n)
            rises_r <= 5'h00;
        else if ($rose(sck))
            rises_r <= rises_r + 5'h01;
    end
    chk_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock moves outside a frame");
    chk_sck_half: assert property ($rose(sck) |-> sck[*5] ##1 !sck)
        else $error("link clock high phase is not five cycles");
    chk_frame_len: assert property ($rose(cs_n) |-> rises_r == 5'h10)
        else $error("frame does not hold sixteen clocks");
    chk_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("data line moved while clock high");
    chk_soft_no_pin: assert property (op_mode == 2'b11
        |-> !reset_output_pin[*3])
        else $error("soft reset drove the reset pin");
    chk_restart_mode: assert property (restart_active |-> ##[0:2] op_mode == 2'b00)
        else $error("restart kept the mode field");
    chk_soft_clear: assert property (op_mode == 2'b11 |-> ##2 op_mode == 2'b00)
        else $error("soft reset left the mode field");
    chk_sleep_nowake: assert property (op_mode == 2'b01 && !wake_source_enabled
        |-> ##[0:3] restart_active)
        else $error("sleep with no wake source did not restart");
    chk_ov_reset: assert property ($rose(primary_overvoltage)
        && primary_overvoltage_reset_enable |-> ##[0:3] restart_active)
        else $error("enabled overvoltage did not restart");
    chk_ov_ignored: assert property ($rose(primary_overvoltage)
        && !primary_overvoltage_reset_enable && op_mode != 2'b01
        |-> !restart_active[*4])
        else $error("disabled overvoltage caused a restart");
    cov_frame: cover property ($rose(cs_n));
    cov_restart: cover property (restart_active);
    cov_stop: cover property (op_mode == 2'b10);
endmodule

// ### tb_top.sv
// Self-checking bench: host port drives the master, device pins observed.
// Assumes the two ends meet only through sbc_spi_if.
`timescale 1ns/1ps
`include "sbc_cfg.svh"
module tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        wake_source_enabled = 1'b0;
    logic        primary_overvoltage = 1'b0;
    logic [7:0]  fault_events = 8'h00;
    logic [15:0] reg_rdata, rd_val, exp_q[$], msk_q[$];
    logic [7:0]  x;
    logic        irq, rd_q = 1'b0, sec, ovr, rpin, rst;
    logic [1:0]  op_mode, thr;
    int          errors = 0, samples_checked = 0, pins = 0, p0;
    wire  [15:0] outs = {10'h000, op_mode, sec, ovr, thr};
    sbc_spi_if spi_link();
    sbc_master u_sbc_master(.clk(clk), .resetn(resetn), .spi(spi_link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
    sbc_device u_sbc_device(.clk(clk), .resetn(resetn), .spi(spi_link),
        .wake_source_enabled(wake_source_enabled),
        .primary_overvoltage(primary_overvoltage),
        .fault_events(fault_events), .op_mode(op_mode),
        .secondary_regulator_enable(sec),
        .primary_overvoltage_reset_enable(ovr),
        .primary_reset_threshold(thr), .reset_output_pin(rpin),
        .restart_active(rst));
    sbc_link_props u_sbc_link_props(.clk(clk), .resetn(resetn),
        .sck(spi_link.sck), .cs_n(spi_link.cs_n), .mosi(spi_link.mosi),
        .wake_source_enabled(wake_source_enabled),
        .primary_overvoltage(primary_overvoltage),
        .primary_overvoltage_reset_enable(ovr), .op_mode(op_mode),
        .reset_output_pin(rpin), .restart_active(rst));
    always #2.5 clk = ~clk;
    task automatic compare_val(input logic [15:0] got, input logic [15:0] e);
        samples_checked++;
        if (got !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic print_verdict();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe: sample mid-cycle.
    always @(posedge clk) rd_q <= reg_read;
    always @(negedge clk) begin
        if (rd_q) begin
            rd_val = reg_rdata;
            if (msk_q[0] !== 16'h0000)
                compare_val(reg_rdata & msk_q[0], exp_q[0]);
            void'(msk_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    // Cycles with the reset pin high are counted to tell a restart from a soft reset.
    always @(posedge clk) if (rpin === 1'b1) pins++;
    task automatic host_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic host_rd(input logic [3:0] a, input logic [15:0] e, m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
    endtask
    // A command write while idle starts a frame; the whole word is the frame.
    task automatic frame(input logic w, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        host_wr(`HOST_CMD, {d, w, a});
        do begin
            host_rd(`HOST_STATUS, 16'h0000, 16'h0000);
            n++;
        end while (rd_val[0] !== 1'b0 && n < 300);
        if (n >= 300) begin
            errors++;
            $display("[ERR] %0t frame never finished", $time);
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic wr_chk(input logic [7:0] d, input logic [15:0] e);
        frame(1'b1, `ADDR_MODE_SUPPLY, d);
        compare_val(outs, e);
    endtask
    initial begin
        void'($urandom(36265));
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        compare_val(outs, 16'h0000);
        host_wr(`HOST_INT_ENABLE, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            x = {i[2], 2'b01, i[1:0], 3'b000} | 8'($urandom & 32'h7);
            wr_chk(x, {10'h000, x[7:6], x[4] | (x[3] & !x[7]), x[2:0]});
            frame(1'b0, `ADDR_MODE_SUPPLY, 8'h00);
            host_rd(`HOST_DATA, {8'h00, x & 8'hdf}, 16'h00ff);
        end
        compare_val({15'h0000, irq}, 16'h0001);
        host_wr(`HOST_INT_CLEAR, 16'h0001);
        host_wr(`HOST_INT_ENABLE, 16'h0000);
        host_wr(4'hf, 16'hffff);
        frame(1'b1, `ADDR_FAULT_STATUS, 8'hff);
        frame(1'b1, `ADDR_FAMILY_ID, 8'h02);
        compare_val({15'h0000, irq}, 16'h0000);
        host_rd(`HOST_INT_ENABLE, 16'h0000, 16'h0001);
        compare_val(outs, {10'h000, x[7:6], x[4] | (x[3] & !x[7]), x[2:0]});
        frame(1'b0, `ADDR_FAMILY_ID, 8'h00);
        host_rd(`HOST_DATA, {8'h00, `FAMILY_ID_VALUE}, 16'h00ff);
        x = 8'($urandom) | 8'h01;
        fault_events <= x;
        @(posedge clk);
        fault_events <= 8'h00;
        frame(1'b0, `ADDR_FAULT_STATUS, 8'h00);
        host_rd(`HOST_DATA, {8'h00, x}, 16'h00ff);
        frame(1'b0, `ADDR_FAULT_STATUS, 8'h00);
        host_rd(`HOST_DATA, 16'h0000, 16'h00ff);
        for (int i = 0; i < 2; i++) begin
            p0 = pins;
            wr_chk(8'h9a | (i[0] << 2), {10'h000, 6'h2a | (i[0] << 2)});
            primary_overvoltage <= 1'b1;
            repeat (6) @(posedge clk);
            primary_overvoltage <= 1'b0;
            repeat (4) @(posedge clk);
            compare_val(outs, i[0] ? 16'h0006 : 16'h002a);
            compare_val(16'(pins != p0), 16'(i));
        end
        wr_chk(8'h43, 16'h0003);
        wake_source_enabled <= 1'b1;
        wr_chk(8'h43, 16'h0013);
        p0 = pins;
        wr_chk(8'hc7, 16'h0000);
        compare_val(16'(pins - p0), 16'h0000);
        print_verdict();
    end
    // Watchdog: twenty-six frames of under two hundred cycles each fit well.
    initial begin
        #400us;
        errors++;
        print_verdict();
    end
endmodule
